//--- verilog/rio_defs.svh
/*
  Register offsets, field positions and reset values of the remote I/O
  signal mapper.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef RIO_DEFS_SVH
`define RIO_DEFS_SVH

// ============================================================
// register byte offsets (APB, aligned words; one each, four for each map)
`define RIO_CTRL_OFS        8'h00
`define RIO_FN_STATE_OFS    8'h04
`define RIO_WORDS_OFS       8'h08
`define RIO_CMD_MAP_OFS     8'h10
`define RIO_STAT_MAP_OFS    8'h20
`define RIO_MAP_WORDS       4

// ============================================================
// field positions
`define RIO_CTRL_WIDE_BIT   0
`define RIO_LANE_W          8
`define RIO_CMD_CODE_W      5
`define RIO_STAT_CODE_W     6
`define RIO_NARROW_BITS     8

// ============================================================
// reset values
`define RIO_CTRL_WIDE_RST   1'b1
`define RIO_CMD_MAP0_RST    32'h01090807
`define RIO_CMD_MAP1_RST    32'h00040302
`define RIO_CMD_MAP2_RST    32'h00000000
`define RIO_CMD_MAP3_RST    32'h00000000
`define RIO_STAT_MAP0_RST   32'h01090807
`define RIO_STAT_MAP1_RST   32'h1B1C0302
`define RIO_STAT_MAP2_RST   32'h0000001D
`define RIO_STAT_MAP3_RST   32'h21201F1E

`endif

//--- verilog/rio_pkg.sv
/*
  Types of the remote I/O signal mapper: function codes and state record.
  Assumes rio_defs.svh on the include path.
*/
`include "rio_defs.svh"

package rio_pkg;

  // ============================================================
  // function codes; declaration order fixes the codes, and the map
  // reset words in the header depend on that order
  localparam int RIO_N_IN  = 27;
  localparam int RIO_N_OUT = 36;

  typedef enum logic [`RIO_CMD_CODE_W-1:0] {
    IN_NONE, IN_FWD, IN_BWD, IN_HALT, IN_BRAKE, IN_PANEL, IN_TCAP,
    IN_SEL0, IN_SEL1, IN_SEL2, IN_SEL3,
    IN_GEN0, IN_GEN1, IN_GEN2, IN_GEN3, IN_GEN4, IN_GEN5, IN_GEN6,
    IN_GEN7, IN_GEN8, IN_GEN9, IN_GEN10, IN_GEN11, IN_GEN12,
    IN_GEN13, IN_GEN14, IN_GEN15
  } rio_in_fn_t;

  typedef enum logic [`RIO_STAT_CODE_W-1:0] {
    OUT_NONE, OUT_FWD_E, OUT_BWD_E, OUT_HALT_E, OUT_BRAKE_E,
    OUT_PANEL_E, OUT_TCAP_E,
    OUT_SEL0_E, OUT_SEL1_E, OUT_SEL2_E, OUT_SEL3_E,
    OUT_GEN0, OUT_GEN1, OUT_GEN2, OUT_GEN3, OUT_GEN4, OUT_GEN5,
    OUT_GEN6, OUT_GEN7, OUT_GEN8, OUT_GEN9, OUT_GEN10, OUT_GEN11,
    OUT_GEN12, OUT_GEN13, OUT_GEN14, OUT_GEN15,
    OUT_FAULT, OUT_WARN, OUT_BUSY, OUT_OVLD, OUT_RUN, OUT_SPD,
    OUT_TLIM, OUT_MAINS, OUT_DIR
  } rio_out_fn_t;

  typedef struct packed {
    logic                      wide;
    logic [3:0][31:0]          cmd_map;
    logic [3:0][31:0]          stat_map;
    logic [RIO_N_IN-1:0]       fn;
    logic [15:0]               stat;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
  } rio_state_t;

endpackage : rio_pkg

//--- verilog/rio_slot.sv
/*
  One command bit position: turns its assigned function code and bit
  value into per-function active and inactive hits.
  Assumes the code field comes from the mapper's assignment register.
*/
`timescale 1ns/1ps
`default_nettype none

module rio_slot #(
  parameter int N_FN   = 27,
  parameter int CODE_W = 5
) (
  // assignment
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              en,
  // command bit
  input  wire logic              bit_in,
  // per-function hits
  output logic      [N_FN-1:0]   hit_on,
  output logic      [N_FN-1:0]   hit_off
);

  // code 0 is the unused slot and codes past the table match nothing
  always_comb begin
    for (int f = 0; f < N_FN; f++) begin
      hit_on[f]  = en && (f != 0) && (code == CODE_W'(f)) && bit_in;
      hit_off[f] = en && (f != 0) && (code == CODE_W'(f)) && !bit_in;
    end
  end

endmodule : rio_slot

`default_nettype wire

//--- verilog/rio_mapper.sv
/*
  Remote I/O signal mapper: maps the remote command word onto the
  driver's input functions and builds the remote status word from the
  driver's state, with assignments held in APB registers.
  Assumes all inputs synchronous to clk; direct terminals arrive already
  decoded per function code.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rio_defs.svh"

module rio_mapper #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ADDR_W-1:0]                 paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // remote words
  input  wire logic [15:0]                       remote_cmd_word,
  output logic      [15:0]                       remote_stat_word,
  // direct terminals, decoded per input function code
  input  wire logic [rio_pkg::RIO_N_IN-1:0]      direct_fn_on,
  input  wire logic [rio_pkg::RIO_N_IN-1:0]      direct_fn_assigned,
  // driver state
  input  wire logic                              fault_flag,
  input  wire logic                              warning_flag,
  input  wire logic                              internal_busy,
  input  wire logic                              overload_flag,
  input  wire logic                              motor_running,
  input  wire logic                              speed_reached,
  input  wire logic                              torque_limit_active,
  input  wire logic                              main_supply_on,
  input  wire logic                              rotation_fwd,
  // decoded input functions
  output logic                                   forward_run,
  output logic                                   backward_run,
  output logic                                   halt_decel,
  output logic                                   brake_release,
  output logic                                   panel_unlock,
  output logic                                   torque_cap,
  output logic      [3:0]                        op_data_select,
  output logic      [15:0]                       general_bits
);

  import rio_pkg::*;

  // ============================================================
  // state
  localparam rio_state_t RST_STATE = '{
    wide:     `RIO_CTRL_WIDE_RST,
    cmd_map:  {`RIO_CMD_MAP3_RST, `RIO_CMD_MAP2_RST,
               `RIO_CMD_MAP1_RST, `RIO_CMD_MAP0_RST},
    stat_map: {`RIO_STAT_MAP3_RST, `RIO_STAT_MAP2_RST,
               `RIO_STAT_MAP1_RST, `RIO_STAT_MAP0_RST},
    fn:       '0,
    stat:     16'h0000,
    prdata:   32'h00000000,
    pready:   1'b0,
    pslverr:  1'b0
  };

  rio_state_t s_q;
  rio_state_t s_d;

  // ============================================================
  // command bit slots
  logic [15:0][RIO_N_IN-1:0] slot_on;
  logic [15:0][RIO_N_IN-1:0] slot_off;

  for (genvar i = 0; i < 16; i++) begin : g_slot
    // narrow mode leaves the high byte out of the exchange
    logic slot_en;
    assign slot_en = s_q.wide || (i < `RIO_NARROW_BITS);
    rio_slot #(
      .N_FN   (RIO_N_IN),
      .CODE_W (`RIO_CMD_CODE_W)
    ) u_slot (
      .code    (s_q.cmd_map[i / 4][(i % 4) * `RIO_LANE_W +:
                                   `RIO_CMD_CODE_W]),
      .en      (slot_en),
      .bit_in  (remote_cmd_word[i]),
      .hit_on  (slot_on[i]),
      .hit_off (slot_off[i])
    );
  end

  // ============================================================
  // function combine, status build, apb
  logic [RIO_N_IN-1:0]         net_on;
  logic [RIO_N_IN-1:0]         net_off;
  logic [RIO_N_IN-1:0]         fn_now;
  logic [RIO_N_OUT-1:0]        fvec;
  logic [`RIO_STAT_CODE_W-1:0] scode;
  logic                        setup;
  logic                        access;
  logic [ADDR_W-1:0]           ofs;
  logic                        hit_ctrl;
  logic                        hit_fn;
  logic                        hit_words;
  logic                        hit_cmd;
  logic                        hit_stat;
  logic [1:0]                  widx;
  logic [31:0]                 rd;

  always_comb begin
    s_d = s_q;

    // unused slots hit nothing, so they are ignored here
    net_on  = '0;
    net_off = '0;
    for (int i = 0; i < 16; i++) begin
      net_on  = net_on | slot_on[i];
      net_off = net_off | slot_off[i];
    end

    // any active terminal turns a function on, except the normally closed inputs below
    fn_now = net_on | direct_fn_on;
    fn_now[IN_NONE] = 1'b0;

    // normally closed inputs: 1 unless some assigned terminal is 0
    fn_now[IN_PANEL] = !(net_off[IN_PANEL] ||
                         (direct_fn_assigned[IN_PANEL] &&
                          !direct_fn_on[IN_PANEL]));
    fn_now[IN_TCAP]  = !(net_off[IN_TCAP] ||
                         (direct_fn_assigned[IN_TCAP] &&
                          !direct_fn_on[IN_TCAP]));
    s_d.fn = fn_now;

    // output function vector indexed by status code
    fvec = '0;
    fvec[OUT_FWD_E]   = fn_now[IN_FWD];
    fvec[OUT_BWD_E]   = fn_now[IN_BWD];
    fvec[OUT_HALT_E]  = fn_now[IN_HALT];
    fvec[OUT_BRAKE_E] = fn_now[IN_BRAKE];
    fvec[OUT_PANEL_E] = fn_now[IN_PANEL];
    fvec[OUT_TCAP_E]  = fn_now[IN_TCAP];
    for (int k = 0; k < 4; k++) begin
      fvec[int'(OUT_SEL0_E) + k] = fn_now[int'(IN_SEL0) + k];
    end
    for (int k = 0; k < 16; k++) begin
      fvec[int'(OUT_GEN0) + k] = fn_now[int'(IN_GEN0) + k];
    end
    fvec[OUT_FAULT] = fault_flag;
    fvec[OUT_WARN]  = warning_flag;
    fvec[OUT_RUN]   = motor_running;
    fvec[OUT_TLIM]  = torque_limit_active;
    fvec[OUT_SPD]   = speed_reached;
    fvec[OUT_BUSY]  = internal_busy;
    fvec[OUT_OVLD]  = overload_flag;
    fvec[OUT_MAINS] = main_supply_on;
    fvec[OUT_DIR]   = rotation_fwd;

    // codes past the table read as unused
    for (int i = 0; i < 16; i++) begin
      scode = s_q.stat_map[i / 4][(i % 4) * `RIO_LANE_W +:
                                  `RIO_STAT_CODE_W];
      if (scode < `RIO_STAT_CODE_W'(RIO_N_OUT)) begin
        s_d.stat[i] = fvec[scode];
      end else begin
        s_d.stat[i] = 1'b0;
      end
      if (!s_q.wide && i >= `RIO_NARROW_BITS) begin
        s_d.stat[i] = 1'b0;
      end
    end

    // apb decode; pready rises in the access phase's first cycle
    setup     = psel && !penable;
    access    = psel && penable && s_q.pready;
    ofs       = paddr;
    widx      = ofs[3:2];
    hit_ctrl  = (ofs == ADDR_W'(`RIO_CTRL_OFS));
    hit_fn    = (ofs == ADDR_W'(`RIO_FN_STATE_OFS));
    hit_words = (ofs == ADDR_W'(`RIO_WORDS_OFS));
    hit_cmd   = (ofs[ADDR_W-1:4] ==
                 (ADDR_W-4)'(`RIO_CMD_MAP_OFS >> 4)) &&
                (ofs[1:0] == 2'b00);
    hit_stat  = (ofs[ADDR_W-1:4] ==
                 (ADDR_W-4)'(`RIO_STAT_MAP_OFS >> 4)) &&
                (ofs[1:0] == 2'b00);

    rd = 32'h00000000;
    if (hit_ctrl) begin
      rd[`RIO_CTRL_WIDE_BIT] = s_q.wide;
    end else if (hit_fn) begin
      rd[RIO_N_IN-1:0] = s_q.fn;
    end else if (hit_words) begin
      rd = {remote_cmd_word, s_q.stat};
    end else if (hit_cmd) begin
      rd = s_q.cmd_map[widx];
    end else if (hit_stat) begin
      rd = s_q.stat_map[widx];
    end

    if (setup) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !(hit_ctrl || hit_fn || hit_words ||
                      hit_cmd || hit_stat);
      s_d.prdata  = pwrite ? 32'h00000000 : rd;
    end else if (access) begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    // writes land at the completing edge; reserved lane bits stay zero
    if (access && pwrite) begin
      if (hit_ctrl && pstrb[0]) begin
        s_d.wide = pwdata[`RIO_CTRL_WIDE_BIT];
      end
      for (int j = 0; j < 4; j++) begin
        if (hit_cmd && pstrb[j]) begin
          s_d.cmd_map[widx][j * `RIO_LANE_W +: `RIO_LANE_W] =
            {3'b000, pwdata[j * `RIO_LANE_W +: `RIO_CMD_CODE_W]};
        end
        if (hit_stat && pstrb[j]) begin
          s_d.stat_map[widx][j * `RIO_LANE_W +: `RIO_LANE_W] =
            {2'b00, pwdata[j * `RIO_LANE_W +: `RIO_STAT_CODE_W]};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs, all straight from the state register
  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign remote_stat_word = s_q.stat;
  assign forward_run      = s_q.fn[IN_FWD];
  assign backward_run     = s_q.fn[IN_BWD];
  assign halt_decel       = s_q.fn[IN_HALT];
  assign brake_release    = s_q.fn[IN_BRAKE];
  assign panel_unlock     = s_q.fn[IN_PANEL];
  assign torque_cap       = s_q.fn[IN_TCAP];
  assign op_data_select   = s_q.fn[int'(IN_SEL0) +: 4];
  assign general_bits     = s_q.fn[int'(IN_GEN0) +: 16];

endmodule : rio_mapper

`default_nettype wire

//--- tb/rio_mapper_props.sv
/*
  Checker of the mapper's apb answer and of function merging.
  Assumes it is bound into rio_mapper and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module rio_mapper_props (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // apb
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // terminals and functions
  input wire logic [rio_pkg::RIO_N_IN-1:0] direct_fn_on,
  input wire logic [rio_pkg::RIO_N_IN-1:0] direct_fn_assigned,
  input wire logic                         forward_run,
  input wire logic                         brake_release,
  input wire logic                         panel_unlock,
  input wire logic                         torque_cap,
  input wire logic [3:0]                   op_data_select,
  input wire logic [15:0]                  general_bits
);
  import rio_pkg::*;
  logic up_q;
  wire logic [RIO_N_IN-1:0] hit = direct_fn_on & direct_fn_assigned;
  wire logic [RIO_N_IN-1:0] low = direct_fn_assigned & ~direct_fn_on;
  wire logic                gen_hit = hit[IN_GEN15];
  // first edge after release still shows reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdy_pulse_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer is not a single cycle");
  err_read_a: assert property (
    pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read carries data");
  fwd_or_a: assert property (
    up_q && hit[IN_FWD] |=> forward_run)
    else $error("forward run missed a direct terminal");
  brake_or_a: assert property (
    up_q && hit[IN_BRAKE] |-> ##1 brake_release)
    else $error("brake release missed a direct terminal");
  panel_and_a: assert property (
    up_q && low[IN_PANEL] |=> !panel_unlock)
    else $error("panel unlock ignored a low terminal");
  tcap_and_a: assert property (
    up_q && low[IN_TCAP] |-> ##1 !torque_cap)
    else $error("torque cap ignored a low terminal");
  sel_or_a: assert property (
    up_q && hit[IN_SEL3] |=> op_data_select[3])
    else $error("select bit missed a direct terminal");
  gen_or_a: assert property (
    $past(up_q) && $past(gen_hit) |-> general_bits[15])
    else $error("general bit missed a direct terminal");
endmodule : rio_mapper_props

bind rio_mapper rio_mapper_props u_props (
  .clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .direct_fn_on, .direct_fn_assigned, .forward_run, .brake_release,
  .panel_unlock, .torque_cap, .op_data_select, .general_bits
);
`default_nettype wire

//--- tb/rio_net_master.sv
/*
  Network converter model: sends the remote command word.
  Assumes the bench sets the word and the exchange width.
*/
`timescale 1ns/1ps
`default_nettype none

module rio_net_master (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // from bench
  input  wire logic        narrow,
  input  wire logic [15:0] cmd_in,
  // to mapper
  output logic      [15:0] cmd_word
);
  logic [7:0] junk_q;
  // lanes not exchanged move every cycle, never a stale value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) junk_q <= 8'h5A;
    else junk_q <= junk_q + 8'h3B;
  end
  assign cmd_word = narrow ? {junk_q, cmd_in[7:0]} : cmd_in;
endmodule : rio_net_master
`default_nettype wire

//--- tb/rio_tb.sv
/*
  Self-checking bench of the mapper: map set-up over apb, random words.
  Assumes rio_pkg, rio_defs.svh and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rio_defs.svh"

module testbench;
  import rio_pkg::*;
  localparam logic [31:0] RST_IMG [9] = '{`RIO_CMD_MAP0_RST,
    `RIO_CMD_MAP1_RST, `RIO_CMD_MAP2_RST, `RIO_CMD_MAP3_RST,
    `RIO_STAT_MAP0_RST, `RIO_STAT_MAP1_RST, `RIO_STAT_MAP2_RST,
    `RIO_STAT_MAP3_RST, 32'h00000001};
  // duplicates, panel/torque AND, dead codes, tail flags, narrow
  localparam logic [35:0] CORNER [5] = '{{4'h0, 32'h01010101},
    {4'h1, 32'h06050605}, {4'h2, 32'h1F1A0B1B}, {4'h7, 32'h23222120},
    {4'h8, 32'h00000000}};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        forward_run, backward_run, halt_decel, brake_release;
  logic        panel_unlock, torque_cap;
  logic [3:0]  pstrb, op_data_select;
  logic [7:0]  paddr;
  logic [8:0]  drv;
  logic [15:0] cmd, remote_cmd_word, remote_stat_word, general_bits;
  logic [26:0] direct_fn_on, direct_fn_assigned, f;
  logic [31:0] pwdata, prdata, rd, g, x;
  logic [31:0] img [9];
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  rio_net_master net_u (.clk, .rst, .narrow(~img[8][0]), .cmd_in(cmd),
    .cmd_word(remote_cmd_word));
  rio_mapper dut_u (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .remote_cmd_word, .remote_stat_word,
    .direct_fn_on, .direct_fn_assigned,
    .fault_flag(drv[0]), .warning_flag(drv[1]), .internal_busy(drv[2]),
    .overload_flag(drv[3]), .motor_running(drv[4]),
    .speed_reached(drv[5]), .torque_limit_active(drv[6]),
    .main_supply_on(drv[7]), .rotation_fwd(drv[8]),
    .forward_run, .backward_run, .halt_decel, .brake_release,
    .panel_unlock, .torque_cap, .op_data_select, .general_bits
  );

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one idle edge first, so release and next setup never collide
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken and request released at the same rising edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] adr(int i);
    return (i == 8) ? 8'h00 : 8'(8'h10 + 4 * i);
  endfunction : adr

  function automatic logic [26:0] fn_exp();
    logic [26:0] hi, lo;
    logic [4:0]  c;
    // an active direct terminal turns its function on by itself, except panel unlock and torque cap
    hi = direct_fn_on;
    lo = direct_fn_assigned & ~direct_fn_on;
    for (int i = 0; i < 16; i++) begin
      c = img[i / 4][(i % 4) * 8 +: 5];
      if ((img[8][0] || i < 8) && c < 5'd27) begin
        if (cmd[i]) hi[c] = 1'b1;
        else lo[c] = 1'b1;
      end
    end
    hi[IN_PANEL] = !lo[IN_PANEL];
    hi[IN_TCAP]  = !lo[IN_TCAP];
    return hi;
  endfunction : fn_exp

  function automatic logic [15:0] st_exp(logic [26:0] fv);
    logic [35:0] src;
    logic [5:0]  c;
    logic [15:0] s;
    src = {drv, fv[26:1], 1'b0};
    s   = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      c = img[4 + i / 4][(i % 4) * 8 +: 6];
      if ((img[8][0] || i < 8) && c < 6'd36) s[i] = src[c];
    end
    return s;
  endfunction : st_exp

  task automatic remap(input int s);
    logic [35:0] e;
    logic [3:0]  sb;
    int          i;
    e  = (s < 5) ? CORNER[s] : {4'($urandom_range(8)), 32'($urandom)};
    sb = (s < 5) ? 4'hF : 4'($urandom);
    i  = int'(e[35:32]);
    apb(1'b1, adr(i), e[31:0], sb);
    for (int j = 0; j < 4; j++) begin
      if (sb[j]) img[i][8 * j +: 8] = e[8 * j +: 8];
    end
    img[i] &= (i == 8) ? 32'h1 : (i > 3) ? 32'h3F3F3F3F : 32'h1F1F1F1F;
    apb(1'b0, adr(i), 32'h0, 4'hF);
    chk(rd, img[i]);
  endtask : remap

  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {cmd, drv, direct_fn_on, direct_fn_assigned} = '0;
    rst = 1'b1;
    img = RST_IMG;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(68539));
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, adr(i), 32'h0, 4'hF);
      chk(rd, img[i]);
    end
    $display("test reset_values done");
    apb(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, 8'h44, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test refused_access done");
    for (int k = 0; k < 400; k++) begin
      if (k % 25 == 24) remap(k / 25);
      @(posedge clk);
      cmd                <= 16'($urandom);
      drv                <= 9'($urandom);
      direct_fn_on       <= 27'($urandom);
      direct_fn_assigned <= (k < 25) ? 27'h0 : 27'($urandom & $urandom);
      @(posedge clk);
      @(negedge clk);
      f = fn_exp();
      g = {6'h0, forward_run, backward_run, halt_decel, brake_release,
           panel_unlock, torque_cap, op_data_select, general_bits};
      x = {6'h0, f[1], f[2], f[3], f[4], f[5], f[6], f[10:7], f[26:11]};
      chk(g >> 16, x >> 16);
      chk(g & 32'hFFFF, x & 32'hFFFF);
      g = {16'h0, remote_stat_word};
      x = {16'h0, st_exp(f)};
      chk(g & 32'hFF, x & 32'hFF);
      chk(g >> 8, x >> 8);
    end
    $display("test random_mapping done");
    apb(1'b0, 8'h04, 32'h0, 4'hF);
    chk({6'h0, rd[26:1]}, {6'h0, f[26:1]});
    apb(1'b0, 8'h08, 32'h0, 4'hF);
    chk({16'h0, rd[15:0]}, {16'h0, st_exp(f)});
    $display("test state_readback done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
